/* pkg/lpa_pkg.sv */
// lpa_pkg: constants for the land pre-pit address encoder
// assumes a 100 MHz system clock and a sync frame pulse from the timebase
package lpa_pkg;
    localparam int ADDR_W      = 24;
    localparam int SET_W       = 3;
    localparam int RELA_W      = 4;
    localparam int USER_W      = 8;
    localparam int FRAME_W     = RELA_W + USER_W;
    localparam int SETS_PER_SEC = 1 + FRAME_W;
    localparam int SECS_PER_BLK = 16;
    localparam int SF_PER_SET  = 2;
    localparam int PART_A_LAST = 5;
    localparam logic [SET_W-1:0] SET_SYNC_EVEN = 3'h7;
    localparam logic [SET_W-1:0] SET_SYNC_ODD  = 3'h6;
    localparam logic [SET_W-1:0] SET_ONE       = 3'h5;
    localparam logic [SET_W-1:0] SET_ZERO      = 3'h4;
    // layer 0 zone starts and block counts
    localparam logic [ADDR_W-1:0] L0_ITEST  = 24'hffe077;
    localparam logic [ADDR_W-1:0] L0_RMA    = 24'hffde31;
    localparam logic [ADDR_W-1:0] L0_LEADIN = 24'hffdbbb;
    localparam logic [ADDR_W-1:0] L0_DATA   = 24'hffcfff;
    localparam logic [ADDR_W-1:0] L0_MIDDLE = 24'hfdd109;
    localparam logic [ADDR_W-1:0] L0_OTEST  = 24'hfdccc9;
    localparam int L0_ITEST_N = 581;
    localparam int L0_RMA_N   = 629;
    localparam int L0_LEADIN_N = 3004;
    localparam int L0_MIDDLE_N = 1088;
    localparam int L0_OTEST_N = 1091;
    // layer 1 zone starts and block counts
    localparam logic [ADDR_W-1:0] L1_ITEST  = 24'h00240a;
    localparam logic [ADDR_W-1:0] L1_RMA    = 24'h0025a2;
    localparam logic [ADDR_W-1:0] L1_LEADOUT = 24'h00336f;
    localparam logic [ADDR_W-1:0] L1_DATA   = 24'h022ef5;
    localparam logic [ADDR_W-1:0] L1_MIDDLE = 24'h023573;
    localparam logic [ADDR_W-1:0] L1_OTEST  = 24'h0239b6;
    localparam int L1_ITEST_N  = 581;
    localparam int L1_RMA_N    = 189;
    localparam int L1_MIDDLE_N = 1662;
    localparam int L1_OTEST_N  = 1091;
    typedef enum logic [2:0] {
        LPA_ZONE_ITEST,
        LPA_ZONE_RMA,
        LPA_ZONE_LEAD,
        LPA_ZONE_DATA,
        LPA_ZONE_MIDDLE,
        LPA_ZONE_OTEST
    } lpa_zone_t;
endpackage

/* hw/lpa_set_map.sv */
// lpa_set_map: maps one slot of a pre-pit sector onto its 3-bit set
// assumes slot 0 is the sync slot and slots 1..12 are frame bits
module lpa_set_map
    import lpa_pkg::*;
(
    input  wire logic [3:0]         slot_i,
    input  wire logic [FRAME_W-1:0] frame_i,
    input  wire logic               odd_i,
    output logic      [SET_W-1:0]   set_o
);
    logic [3:0] bit_idx;
    always_comb begin
        bit_idx = 4'(FRAME_W) - slot_i;
        if (slot_i == 4'h0) begin
            set_o = odd_i ? SET_SYNC_ODD : SET_SYNC_EVEN;
        end else if (frame_i[bit_idx]) begin
            set_o = SET_ONE;
        end else begin
            set_o = SET_ZERO;
        end
    end
endmodule

/* hw/lpa_encoder.sv */
// lpa_encoder: land pre-pit block encoder, one set per two sync frames
// assumes sf_pulse_i marks each sync frame start, one cycle wide, pulses
// at least two clocks apart, and the user supplies block address, part B
// bytes and parities
// How it works
// - pre-pit block address is the absolute physical track address.
// - addresses fall outward on layer 0, inward on layer 1.
// - first data block on layer 0 after lead-in is ffcfff.
// - layer 0 zone starts and block counts are fixed constants.
// - layer 1 zone starts and block counts are fixed constants.
// - one pre-pit sequence spans sixteen sectors, one ecc block.
// - one 3-bit set per two sync frames, msb first.
// - each sector opens with a sync set; lead bit is frame sync.
// - sync set is 111 even, 110 odd.
// - data one is 101, data zero is 100.
// - even position normally; odd when neighbour land has a pit.
// - data frame is 4-bit relative address then 8-bit user data.
// - sector is sync set, 4 address bits, 8 data bits.
// - a data block is sixteen frames, one per sector.
// - frames 0..5 carry address and parity a, rest part b.
module lpa_encoder
    import lpa_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                reset_i,
    input  wire logic                start_i,
    input  wire logic                layer_i,
    input  wire logic [ADDR_W-1:0]   blk_addr_i,
    input  wire logic [23:0]         parity_a_i,
    input  wire logic [79:0]         part_b_i,
    input  wire logic                sf_pulse_i,
    input  wire logic                neighbour_pit_i,
    output logic                     busy_o,
    output logic                     load_o,
    output logic                     pit_o,
    output logic                     pit_odd_o,
    output logic                     pit_valid_o,
    output logic      [ADDR_W-1:0]   next_addr_o,
    output logic      [2:0]          zone_o
);
    typedef enum logic {
        LPA_IDLE,
        LPA_RUN
    } lpa_state_t;

    lpa_state_t        state_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [23:0]       par_reg;
    logic [79:0]       partb_reg;
    logic [3:0]        sec_reg;
    logic [3:0]        slot_reg;
    logic [1:0]        bit_reg;
    logic              half_reg;
    logic              odd_reg;
    logic [SET_W-1:0]  set_next;
    logic [1:0]        bit_pos;
    logic              set_start;
    logic [USER_W-1:0] user_byte;
    logic [FRAME_W-1:0] frame;
    logic              set_done;
    logic              sec_done;
    lpa_zone_t         zone;

    // part a bytes: addr msb first then parity a; part b in order
    always_comb begin
        case (sec_reg)
            4'h0: user_byte = addr_reg[23:16];
            4'h1: user_byte = addr_reg[15:8];
            4'h2: user_byte = addr_reg[7:0];
            4'h3: user_byte = par_reg[23:16];
            4'h4: user_byte = par_reg[15:8];
            4'h5: user_byte = par_reg[7:0];
            default: user_byte = partb_reg[8'(79 - 8*(sec_reg - 6)) -: 8];
        endcase
        frame = {sec_reg, user_byte};
    end

    lpa_set_map u_map (
        .slot_i  (slot_reg),
        .frame_i (frame),
        .odd_i   (odd_reg),
        .set_o   (set_next)
    );

    assign set_done  = sf_pulse_i && half_reg;
    assign set_start = (state_reg == LPA_RUN) && sf_pulse_i && !half_reg;
    assign bit_pos   = set_start ? 2'(SET_W - 1) : 2'(SET_W - 1) - bit_reg;
    assign sec_done = set_done && (slot_reg == 4'(SETS_PER_SEC - 1));

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= LPA_IDLE;
        end else if (state_reg == LPA_IDLE) begin
            if (start_i) state_reg <= LPA_RUN;
        end else if (sec_done && sec_reg == 4'(SECS_PER_BLK - 1)) begin
            state_reg <= LPA_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            addr_reg    <= '0;
            par_reg     <= '0;
            partb_reg   <= '0;
            next_addr_o <= '0;
            zone_o      <= '0;
        end else if (state_reg == LPA_IDLE && start_i) begin
            addr_reg    <= blk_addr_i;
            par_reg     <= parity_a_i;
            partb_reg   <= part_b_i;
            next_addr_o <= blk_addr_i - 24'h000001;
            zone_o      <= zone;
        end
    end

    // sequencing: bit within set, slot within sector, sector within block
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            sec_reg  <= '0;
            slot_reg <= '0;
            bit_reg  <= '0;
            half_reg <= 1'b0;
        end else if (state_reg == LPA_IDLE) begin
            sec_reg  <= '0;
            slot_reg <= '0;
            bit_reg  <= '0;
            half_reg <= 1'b0;
        end else begin
            if (sf_pulse_i) begin
                half_reg <= ~half_reg;
            end
            // b2 leaves on the even sync frame, b1 and b0 on the next clocks
            if (set_start) begin
                bit_reg <= 2'd1;
            end else if (bit_reg != 2'd0) begin
                bit_reg <= (bit_reg == 2'd2) ? 2'd0 : bit_reg + 2'd1;
            end
            if (sec_done) begin
                slot_reg <= '0;
                sec_reg  <= sec_reg + 4'h1;
            end else if (set_done) begin
                slot_reg <= slot_reg + 4'h1;
            end
        end
    end

    // position picked per set so it may change mid-sector
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            odd_reg <= 1'b0;
        end else if (state_reg == LPA_IDLE ||
                     (set_done && !(sec_done &&
                      sec_reg == 4'(SECS_PER_BLK - 1)))) begin
            odd_reg <= neighbour_pit_i;
        end
    end

    // three bits of a set on consecutive clocks, msb first
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            pit_o       <= 1'b0;
            pit_odd_o   <= 1'b0;
            pit_valid_o <= 1'b0;
        end else begin
            pit_valid_o <= set_start || (bit_reg != 2'd0);
            pit_o       <= set_next[bit_pos];
            pit_odd_o   <= odd_reg;
        end
    end

    // zone of the offered address: down outward on l0, down inward on l1
    always_comb begin
        if (!layer_i) begin
            if (blk_addr_i > L0_LEADIN) zone = LPA_ZONE_ITEST;
            else if (blk_addr_i > L0_DATA) zone = LPA_ZONE_LEAD;
            else if (blk_addr_i > L0_MIDDLE) zone = LPA_ZONE_DATA;
            else if (blk_addr_i > L0_OTEST) zone = LPA_ZONE_MIDDLE;
            else zone = LPA_ZONE_OTEST;
            if (blk_addr_i <= L0_ITEST && blk_addr_i > L0_RMA)
                zone = LPA_ZONE_ITEST;
            else if (blk_addr_i <= L0_RMA && blk_addr_i > L0_LEADIN)
                zone = LPA_ZONE_RMA;
        end else begin
            if (blk_addr_i < L1_RMA) zone = LPA_ZONE_ITEST;
            else if (blk_addr_i < L1_LEADOUT) zone = LPA_ZONE_RMA;
            else if (blk_addr_i < L1_DATA) zone = LPA_ZONE_LEAD;
            else if (blk_addr_i < L1_MIDDLE) zone = LPA_ZONE_DATA;
            else if (blk_addr_i < L1_OTEST) zone = LPA_ZONE_MIDDLE;
            else zone = LPA_ZONE_OTEST;
        end
    end
    assign busy_o = (state_reg == LPA_RUN);
    assign load_o = (state_reg == LPA_IDLE);
endmodule

/* tb/lpa_reader.sv */
// lpa_reader: drive-side model that decodes the land pre-pit bit stream
// assumes one pit bit per pit_valid pulse, sets arrive b2 first
module lpa_reader (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        valid_i,
    input  wire logic        pit_i,
    output logic             frm_o,
    output logic             err_o,
    output logic [11:0]      frame_o
);
    logic [2:0] s;
    logic [1:0] k;
    int         idx;
    always @(posedge clk_i or posedge reset_i) begin
        frm_o <= 1'b0;
        if (reset_i) begin
            k <= 2'h0; idx <= 0; err_o <= 1'b0; s = 3'h0;
        end else if (valid_i) begin
            s = {s[1:0], pit_i};
            k <= (k == 2'h2) ? 2'h0 : k + 2'h1;
            if (k == 2'h2) begin
                if (!s[2]) err_o <= 1'b1;
                else if (s[1]) begin
                    if (idx != 0 && idx != 13) err_o <= 1'b1;
                    idx <= 1;
                end else begin
                    frame_o <= {frame_o[10:0], s[0]};
                    idx <= idx + 1;
                    frm_o <= (idx == 12);
                end
            end
        end
    end
endmodule

/* tb/lpa_encoder_sva.sv */
// lpa_encoder_sva: port-level checks of the pre-pit encoder
// assumes bits of a block start right after start is taken
module lpa_encoder_sva (
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    input wire logic        start_i,
    input wire logic [23:0] blk_addr_i,
    input wire logic        sf_pulse_i,
    input wire logic        busy_o,
    input wire logic        load_o,
    input wire logic        pit_o,
    input wire logic        pit_odd_o,
    input wire logic        pit_valid_o,
    input wire logic [23:0] next_addr_o
);
    logic [5:0]  bit_q;
    logic [9:0]  tot_q;
    logic [9:0]  sf_q;
    logic [23:0] addr_q;
    always_ff @(posedge clk_sys_i or posedge reset_i)
        if (reset_i || load_o) bit_q <= 6'h0;
        else if (pit_valid_o) bit_q <= (bit_q == 6'd38) ? 6'h0 : bit_q + 6'h1;
    always_ff @(posedge clk_sys_i or posedge reset_i)
        if (reset_i || load_o) tot_q <= 10'h0;
        else if (pit_valid_o) tot_q <= tot_q + 10'h1;
    always_ff @(posedge clk_sys_i or posedge reset_i)
        if (reset_i || load_o) sf_q <= 10'h0;
        else if (sf_pulse_i) sf_q <= sf_q + 10'h1;
    always_ff @(posedge clk_sys_i or posedge reset_i)
        if (reset_i) addr_q <= 24'h0;
        else if (start_i && load_o) addr_q <= blk_addr_i;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    a_start_to_busy: assert property (start_i && load_o
        |=> busy_o && !load_o)
        else $error("start not taken");
    a_idle_quiet: assert property (load_o && $past(load_o)
        |-> !pit_valid_o)
        else $error("pit bit while idle");
    a_valid_after_sf: assert property (pit_valid_o && bit_q % 3 == 0
        |-> $past(sf_pulse_i))
        else $error("set does not start on a sync frame");
    a_set_burst: assert property (pit_valid_o && bit_q % 3 != 2
        |=> pit_valid_o)
        else $error("set bits not back to back");
    a_set_pace: assert property (pit_valid_o && bit_q % 3 == 0
        |-> sf_q == 10'(2 * (tot_q / 3) + 1))
        else $error("set not one per two sync frames");
    a_lead_bit: assert property (pit_valid_o && bit_q % 3 == 0
        |-> pit_o)
        else $error("lead bit of set is zero");
    a_sync_mid: assert property (pit_valid_o && bit_q == 1
        |-> pit_o)
        else $error("sync middle bit is zero");
    a_sync_tail: assert property (pit_valid_o && bit_q == 2
        |-> pit_o != pit_odd_o)
        else $error("sync last bit wrong for position");
    a_data_mid: assert property (pit_valid_o && bit_q > 2
        && bit_q % 3 == 1 |-> !pit_o)
        else $error("data middle bit is one");
    a_next_addr: assert property (busy_o
        |-> next_addr_o == addr_q - 24'h1)
        else $error("next address wrong");
    a_block_len: assert property ($fell(busy_o)
        |-> tot_q == 10'd624 || (tot_q == 10'd623 && pit_valid_o))
        else $error("block bit count wrong");
    c_start: cover property (start_i && load_o);
    c_odd_sync: cover property (pit_valid_o && bit_q == 2 && pit_odd_o);
    c_end: cover property ($fell(busy_o));
endmodule

/* tb/lpa_encoder_bench.sv */
// lpa_encoder_bench: self-checking bench for the pre-pit encoder
// assumes a sync frame pulse every second clock while a block runs
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module lpa_encoder_bench;
    import lpa_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 0, reset_i = 1, start_i = 0, layer_i = 0, tog = 0;
    logic sf_pulse_i = 0, neighbour_pit_i = 0, sf_en = 0;
    logic [23:0] blk_addr_i = 0, parity_a_i = 0;
    logic [79:0] part_b_i = 0;
    logic busy_o, load_o, pit_o, pit_odd_o, pit_valid_o, frm, err;
    logic [23:0] next_addr_o;
    logic [2:0]  zone_o;
    logic [11:0] frame;
    int failures = 0, cmp_count = 0, seed = 32'hf8ba;
    logic bq[$];
    logic [11:0] fq[$];
    logic [23:0] za[12] = '{L0_ITEST, L0_RMA, L0_LEADIN, L0_DATA, L0_MIDDLE,
        L0_OTEST, L1_ITEST, L1_RMA, L1_LEADOUT, L1_DATA, L1_MIDDLE, L1_OTEST};
    lpa_encoder dut (.clk_sys_i, .reset_i, .start_i, .layer_i, .blk_addr_i,
        .parity_a_i, .part_b_i, .sf_pulse_i, .neighbour_pit_i, .busy_o,
        .load_o, .pit_o, .pit_odd_o, .pit_valid_o, .next_addr_o, .zone_o);
    lpa_reader drv (.clk_i(clk_sys_i), .reset_i, .valid_i(pit_valid_o),
        .pit_i(pit_o), .frm_o(frm), .err_o(err), .frame_o(frame));
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        sf_pulse_i <= sf_en & ~sf_pulse_i;
        if (tog) neighbour_pit_i <= 1'($random(seed));
    end
    always @(posedge clk_sys_i) begin
        logic e;
        logic [11:0] f;
        if (pit_valid_o && !tog) begin
            e = bq.pop_front();
            `CHK(pit_o, e)
            `CHK(pit_odd_o, neighbour_pit_i)
        end
        if (frm) begin
            f = fq.pop_front();
            `CHK(frame, f)
        end
    end
    task automatic run(input logic lay, input logic [23:0] a,
                       input logic nb, input logic t, input logic [2:0] z);
        logic [7:0]  by;
        logic [11:0] fb;
        int n;
        layer_i <= lay; blk_addr_i <= a; neighbour_pit_i <= nb; tog <= t;
        parity_a_i <= 24'($random(seed));
        part_b_i <= {$random(seed), $random(seed), 16'($random(seed))};
        @(posedge clk_sys_i);
        start_i <= 1'b1;
        for (int s = 0; s < 16; s++) begin
            by = s < 3 ? blk_addr_i[23-8*s -: 8] : s < 6 ?
                 parity_a_i[47-8*s -: 8] : part_b_i[127-8*s -: 8];
            fb = {4'(s), by};
            fq.push_back(fb);
            if (!t) begin
                bq.push_back(1); bq.push_back(1); bq.push_back(!nb);
                for (int b = 11; b >= 0; b--) begin
                    bq.push_back(1); bq.push_back(0); bq.push_back(fb[b]);
                end
            end
        end
        @(posedge clk_sys_i);
        start_i <= 1'b0; sf_en <= 1'b1;
        #1 `CHK(busy_o, 1'b1)
        `CHK(zone_o, z)
        @(posedge clk_sys_i);
        start_i <= 1'b1; blk_addr_i <= ~a;
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        #1 `CHK(next_addr_o, a - 24'h1)
        n = 0;
        while (load_o !== 1'b1 && n < 4000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n == 4000) begin failures++; end_sim(); end
        sf_en <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        `CHK(bq.size(), 0)
        `CHK(fq.size(), 0)
        `CHK(err, 1'b0)
        $display("test done layer %0d addr %h", lay, a);
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 12; i++) run(i >= 6, za[i], i[0], 0, 3'(i % 6));
        run(0, L0_MIDDLE + 24'h1, 0, 1, 3'h3);
        end_sim();
    end
endmodule
bind lpa_encoder lpa_encoder_sva chk (.clk_sys_i, .reset_i, .start_i,
    .blk_addr_i, .sf_pulse_i, .busy_o, .load_o, .pit_o, .pit_odd_o,
    .pit_valid_o, .next_addr_o);
